/* File: hw/sram_host_pkg.sv */
// Purpose: constants for the host controller of a 16k x 1 asynchronous static memory
// Assumes: mclk at 200 MHz; slowest speed grade timing used for every limit
// Notes: the access, write, float and recovery figures are rounded up to whole mclk cycles below
// Summary of operation
// - strobe held high throughout reads
// - address stable while selected and strobing
// - zero address setup and hold
// - address valid and strobe width minimum
// - select held minimum before write end
// - data setup before write end, zero hold
// - accesses spaced by cycle time
// - deselect before lowering supply
// - stay deselected one cycle after retention
// - power-down variant ready at select low
package sram_host_pkg;
	// =====================================================
	// geometry
	localparam int ADDR_W = 14;
	localparam int CNT_W  = 4;
	// =====================================================
	// timing in ns and derived cycle counts
	localparam int CLK_PERIOD_NS              = 5;
	localparam int ADDRESS_ACCESS_TIME_NS     = 35;
	localparam int SELECT_TO_OUTPUT_FLOAT_NS  = 13;
	localparam int ADDRESS_VALID_TO_WRITE_END_NS = 30;
	localparam int SELECT_TO_WRITE_END_NS     = 32;
	localparam int WRITE_DATA_SETUP_NS        = 15;
	localparam int READ_CYCLE_TIME_NS         = 35;
	localparam int RETENTION_RECOVERY_TIME_NS = READ_CYCLE_TIME_NS;
	// round up: least times
	localparam int RD_CYC_I  = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_CYC_I  = (SELECT_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLT_CYC_I = (SELECT_TO_OUTPUT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REC_CYC_I = (RETENTION_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'(RD_CYC_I);
	localparam logic [CNT_W-1:0] WR_CYC  = CNT_W'(WR_CYC_I);
	localparam logic [CNT_W-1:0] FLT_CYC = CNT_W'(FLT_CYC_I);
	localparam logic [CNT_W-1:0] REC_CYC = CNT_W'(REC_CYC_I);
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	// =====================================================
	// controller states
	typedef enum logic [4:0] {
		ST_IDLE   = 5'b0_0001,
		ST_READ   = 5'b0_0010,
		ST_WRITE  = 5'b0_0100,
		ST_FLOAT  = 5'b0_1000,
		ST_RECOV  = 5'b1_0000
	} host_state_t;
endpackage

/* File: hw/sram_host.sv */
// Purpose: synchronous host that reads and writes one bit of the static memory
// Assumes: data_out_pin sampled directly in the mclk domain
// Notes: every access brackets select; address and data change only while deselected
module sram_host (
	input  wire logic                              mclk,          // 200 MHz clock
	input  wire logic                              rst_b,         // async reset, low
	input  wire logic                              req,           // access request
	input  wire logic                              req_write,     // 1 write, 0 read
	input  wire logic [sram_host_pkg::ADDR_W-1:0]  req_addr,      // cell address
	input  wire logic                              req_wdata,     // bit to write
	input  wire logic                              retain_req,    // ask for retention
	output logic                                   busy,          // access under way
	output logic                                   rd_valid,      // read bit ready pulse
	output logic                                   rd_data,       // read bit
	output logic                                   retain_ok,     // supply may drop
	output logic [sram_host_pkg::ADDR_W-1:0]       address_pin,   // memory address
	output logic                                   chip_select_n, // select, low
	output logic                                   write_enable_n,// write strobe, low
	output logic                                   data_in_pin,   // write data
	input  wire logic                              data_out_pin   // read data
);
	import sram_host_pkg::*;

	// =====================================================
	// state
	host_state_t              state_ff;
	host_state_t              nxt_state;
	logic [CNT_W-1:0]         cnt_ff;
	logic [CNT_W-1:0]         nxt_cnt;
	logic                     retained_ff;

	wire cnt_done   = (cnt_ff == CNT_ONE);
	wire start      = (state_ff == ST_IDLE) && req && !retain_req && !retained_ff;
	wire rd_end     = (state_ff == ST_READ) && cnt_done;
	wire wr_end     = (state_ff == ST_WRITE) && cnt_done;
	// retention leaves with recovery; recovery keeps select high one read cycle
	wire rec_start  = retained_ff && !retain_req;

	// =====================================================
	// sequencing
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = (cnt_ff == CNT_ZERO) ? CNT_ZERO : cnt_ff - CNT_ONE;
		case (state_ff)
			ST_IDLE:
			begin
				if (rec_start)
				begin
					nxt_state = ST_RECOV;
					nxt_cnt   = REC_CYC;
				end
				else if (start && req_write)
				begin
					nxt_state = ST_WRITE;
					nxt_cnt   = WR_CYC;
				end
				else if (start)
				begin
					nxt_state = ST_READ;
					nxt_cnt   = RD_CYC;
				end
			end
			ST_READ, ST_WRITE:
			begin
				if (rd_end || wr_end)
				begin
					// deselected gap lets the output float before the next access
					nxt_state = ST_FLOAT;
					nxt_cnt   = FLT_CYC;
				end
			end
			ST_FLOAT, ST_RECOV:
			begin
				if (cnt_done)
					nxt_state = ST_IDLE;
			end
			default:
			begin
				nxt_state = ST_IDLE;
				nxt_cnt   = CNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			cnt_ff <= CNT_ZERO;
		else
			cnt_ff <= nxt_cnt;
	end

	// =====================================================
	// pins: select and strobe fall together, rise together at write end
	wire              in_rw     = (nxt_state == ST_READ) || (nxt_state == ST_WRITE);
	wire              nxt_sel_n = !in_rw;
	wire              nxt_we_n  = !(nxt_state == ST_WRITE);
	// address and data move only at a take edge and stand through the float gap,
	// so the zero hold after a write end never races the select edge
	wire              load_req  = start && !rec_start;
	wire [ADDR_W-1:0] nxt_addr  = load_req ? req_addr : address_pin;
	wire              nxt_din   = load_req ? req_wdata : data_in_pin;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			chip_select_n  <= 1'b1;
			write_enable_n <= 1'b1;
		end
		else
		begin
			chip_select_n  <= nxt_sel_n;
			write_enable_n <= nxt_we_n;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			address_pin <= '0;
			data_in_pin <= 1'b0;
		end
		else
		begin
			address_pin <= nxt_addr;
			data_in_pin <= nxt_din;
		end
	end

	// =====================================================
	// read capture on the last selected edge, before select rises; this leaves
	// no margin past the slowest access time, so a faster clock needs a longer window
	wire              nxt_rd_data = rd_end ? data_out_pin : rd_data;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			rd_valid <= 1'b0;
		else
			rd_valid <= rd_end;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			rd_data <= 1'b0;
		else
			rd_data <= nxt_rd_data;
	end

	// =====================================================
	// retention: granted only while idle, so select is already high when supply drops
	wire              grant_ok     = (state_ff == ST_IDLE) && retain_req;
	wire              nxt_retained = grant_ok ? 1'b1 : (rec_start ? 1'b0 : retained_ff);
	// busy also covers the grant, so no request slips in while the supply falls
	wire              nxt_busy     = (nxt_state != ST_IDLE) || retain_req;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			retained_ff <= 1'b0;
		else
			retained_ff <= nxt_retained;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			retain_ok <= 1'b0;
		else
			retain_ok <= grant_ok;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			busy <= 1'b0;
		else
			busy <= nxt_busy;
	end
endmodule // sram_host

/* File: verif/sram_host_monitor.sv */
// Purpose: port checker for the static memory host
// Assumes: one mclk domain, rst_b async low
// Notes: windows are the slowest grade in 5 ns cycles
module sram_host_monitor (
	input wire logic                             mclk,           // clock
	input wire logic                             rst_b,          // reset
	input wire logic                             rd_valid,       // read pulse
	input wire logic                             rd_data,        // read bit
	input wire logic                             retain_ok,      // retention grant
	input wire logic [sram_host_pkg::ADDR_W-1:0] address_pin,    // address
	input wire logic                             chip_select_n,  // select
	input wire logic                             write_enable_n, // strobe
	input wire logic                             data_out_pin    // memory output
);
	timeunit 1ns;
	timeprecision 100ps;
	import sram_host_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// =====
	// access: seven cycles selected, then three deselected
	sequence s_held; !chip_select_n [*7]; endsequence
	sequence s_gap; chip_select_n [*3]; endsequence
	sel_window_a: assert property ($fell(chip_select_n) |-> s_held ##1 s_gap)
		else $error("select window wrong");
	addr_steady_a: assert property (!chip_select_n ##1 !chip_select_n |-> $stable(address_pin))
		else $error("address moved while selected");
	strobe_in_sel_a: assert property (!write_enable_n |-> !chip_select_n)
		else $error("strobe outside select");
	strobe_width_a: assert property ($fell(write_enable_n) |-> !write_enable_n [*6])
		else $error("strobe too short");
	rd_strobe_a: assert property ($fell(chip_select_n) && write_enable_n |-> write_enable_n [*7])
		else $error("strobe fell in read");
	rd_answer_a: assert property (rd_valid == ($rose(chip_select_n) && $past(write_enable_n)))
		else $error("read pulse misplaced");
	rd_data_a: assert property (rd_valid |-> rd_data == $past(data_out_pin))
		else $error("read bit wrong");
	retain_desel_a: assert property (retain_ok |-> chip_select_n)
		else $error("selected in retention");
endmodule // sram_host_monitor
bind sram_host sram_host_monitor u_mon (.mclk, .rst_b, .rd_valid, .rd_data, .retain_ok,
	.address_pin, .chip_select_n, .write_enable_n, .data_out_pin);

/* File: verif/sram_model.sv */
// Purpose: behavioural 16k x 1 static memory
// Assumes: ACC_NS below the host's sampling point
// Notes: undriven output shows the inverse bit
module sram_model #(parameter int ACC_NS = 30) (
	input wire logic [13:0] addr,  // address
	input wire logic        sel_n, // select, low
	input wire logic        we_n,  // strobe, low
	input wire logic        din,   // write bit
	output logic            q      // read bit
);
	timeunit 1ns;
	timeprecision 100ps;
	logic mem [0:16383];
	logic rd;
	logic standby;
	assign rd = mem[addr];
	assign standby = sel_n;
	always @(addr, sel_n, we_n, rd)
	begin
		q <= #5 ~rd;
		if (!standby && we_n)
			q <= #(ACC_NS) rd;
	end
	always @*
		if (!sel_n && !we_n)
			mem[addr] = din;
endmodule // sram_model

/* File: verif/tb_sram_host.sv */
// Purpose: self-checking bench for the static memory host
// Assumes: rows are {write, address, bit}
// Notes: bit is write data or expected read
module tb_sram_host;
	timeunit 1ns;
	timeprecision 100ps;
	import sram_host_pkg::*;
	logic              mclk, rst_b, req, req_write, req_wdata, retain_req, busy, rd_valid;
	logic              rd_data, retain_ok, chip_select_n, write_enable_n, data_in_pin, data_out_pin;
	logic [ADDR_W-1:0] req_addr, address_pin;
	int                fail_count, tests_run, n;
	logic [15:0]       rows [8] = '{16'h8001, 16'hFFFE, 16'hAAAB, 16'h0001,
		16'h7FFE, 16'h2AAB, 16'h8000, 16'h0000};
	sram_host DUT (.mclk, .rst_b, .req, .req_write, .req_addr, .req_wdata, .retain_req, .busy,
		.rd_valid, .rd_data, .retain_ok, .address_pin, .chip_select_n, .write_enable_n,
		.data_in_pin, .data_out_pin);
	sram_model mem_model (.addr(address_pin), .sel_n(chip_select_n), .we_n(write_enable_n),
		.din(data_in_pin), .q(data_out_pin));
	task automatic check(input string what, input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic guard;
		if (n >= 40)
		begin
			fail_count++;
			conclude();
		end
	endtask
	task automatic drive(input logic [15:0] row);
		@(posedge mclk);
		req <= 1'b1;
		req_write <= row[15];
		req_addr <= row[14:1];
		req_wdata <= row[0];
	endtask
	task automatic finish(input logic [15:0] row);
		logic got;
		@(posedge mclk);
		req <= 1'b0;
		got = 1'b0;
		n = 0;
		do
		begin
			@(posedge mclk);
			#1;
			n++;
			if (rd_valid === 1'b1)
			begin
				got = 1'b1;
				check("rd_data", rd_data, row[0]);
			end
		end while (busy !== 1'b0 && n < 40);
		guard();
		check("rd_valid", got, !row[15]);
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial
	begin
		{rst_b, req, req_write, req_wdata, retain_req, req_addr} = '0;
		fail_count = 0;
		tests_run = 0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		foreach (rows[i])
		begin
			drive(rows[i]);
			finish(rows[i]);
		end
		// ========
		// a request held through retention waits out the recovery
		@(posedge mclk);
		retain_req <= 1'b1;
		drive(16'h7FFE);
		repeat (10) @(posedge mclk);
		#1;
		check("retain_ok", retain_ok, 1'b1);
		check("chip_select_n", chip_select_n, 1'b1);
		@(posedge mclk);
		retain_req <= 1'b0;
		for (n = 0; n < 40 && chip_select_n !== 1'b0; n++)
		begin
			@(posedge mclk);
			#1;
		end
		guard();
		check("recovery", n >= 7, 1'b1);
		finish(16'h7FFE);
		// reset in mid-write must deselect at once
		drive(16'h8001);
		repeat (4) @(posedge mclk);
		rst_b <= 1'b0;
		req <= 1'b0;
		#1;
		check("chip_select_n", chip_select_n, 1'b1);
		check("write_enable_n", write_enable_n, 1'b1);
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		drive(16'h0001);
		finish(16'h0001);
		conclude();
	end
endmodule // tb_sram_host
